// *** rtl/result_buffer.sv ***
`timescale 1ns/10ps
`default_nettype none
module result_buffer
    import sar_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    // Streams
    result_if.snk in_s,
    result_if.src out_s
);

    logic [DATA_W-1:0] mem [2];
    logic wr_ptr;
    logic rd_ptr;
    logic [1:0] count;
    logic push;
    logic pop;

    // Honest full and empty
    assign in_s.ready = (count != 2'h2);
    assign out_s.valid = (count != 2'h0);
    assign out_s.data = mem[rd_ptr];
    assign push = in_s.valid & in_s.ready;
    assign pop = out_s.valid & out_s.ready;

    // Storage
    always_ff @(posedge sys_clk_i) begin
        if (push) begin
            mem[wr_ptr] <= in_s.data;
        end
    end

    // Pointers and fill level
    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            count <= 2'h0;
        end else begin
            wr_ptr <= wr_ptr ^ push;
            rd_ptr <= rd_ptr ^ pop;
            count <= 2'(count + {1'b0, push} - {1'b0, pop});
        end
    end

endmodule
`default_nettype wire

// *** rtl/result_if.sv ***
`timescale 1ns/10ps
`default_nettype none
interface result_if;
    logic valid;
    logic ready;
    logic [15:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// *** rtl/sar_adc_readout.sv ***
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// (R01) Host spaces convert strobes by mode minimum
// (R02) Fastest mode: restart within one millisecond
// (R03) Busy rises promptly after strobe falls
// (R04) Busy width bounded by mode
// (R05) Conversion completes within mode limit
// (R06) Busy falls after internal end
// (R07) Parallel result valid within mode limit
// (R08) Parallel data valid before busy falls
// (R09) Read request drives parallel data quickly
// (R10) Chip select low drives serial pins
// (R11) Chip select high releases serial pins
// (R12) Frame marker asserted after conversion
// (R13) Busy falls shortly after frame ends
// (R14) Divider code sets least clock period
// (R15) Divider code bounds longest clock period
// (R16) Gap from frame to first edge
// (R17) Gap from last edge to frame
// (R18) Fastest mode serial busy width bound
// (R19) Normal mode serial busy width bound
// (R20) Reduced power serial busy width bound
// (R21) Slave data follows external clock edge
// (R22) Fast high, low-power low: fastest mode
// (R23) Low-power high, fast low: reduced power
// (R24) Otherwise normal mode timing
module sar_adc_readout
    import sar_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    // Conversion control
    input wire logic convert_strobe_n_i,
    input wire logic fast_mode_i,
    input wire logic low_power_i,
    input wire logic [15:0] sample_code_i,
    // Port selection
    input wire logic serial_select_i,
    input wire logic master_select_i,
    input wire logic [1:0] clock_divider_select_i,
    // Parallel port
    input wire logic chip_select_n_i,
    input wire logic read_n_i,
    output logic [15:0] data_o,
    output logic data_oe_o,
    // Serial port
    input wire logic ext_sclk_i,
    input wire logic serial_data_in_i,
    output logic frame_o,
    output logic frame_oe_o,
    output logic sclk_o,
    output logic sclk_oe_o,
    output logic serial_data_out_o,
    output logic serial_data_out_oe_o,
    // Status
    output logic busy_o
);

    typedef enum logic [3:0] {
        CV_IDLE = 4'b0001,
        CV_CONV = 4'b0010,
        CV_PUSH = 4'b0100,
        CV_DRAIN = 4'b1000
    } conv_state_type;

    logic [10:0] pin_meta;
    logic [10:0] pin_sync;
    logic strobe_n_s;
    logic cs_n_s;
    logic rd_n_s;
    logic ext_sclk_s;
    logic sdi_s;
    logic fast_s;
    logic low_s;
    logic ser_s;
    logic mst_s;
    logic [1:0] div_s;
    logic strobe_prev;
    logic sclk_prev;
    logic start;
    logic ext_fall;
    mode_type next_mode;
    mode_type mode;
    conv_state_type state;
    logic [3:0] cnt;
    logic [15:0] code;
    logic conv_ser;
    logic conv_mst;
    logic par_landed;
    logic shift_done;
    logic shift_frame;
    logic shift_sclk;
    logic shift_sdo;
    logic ser_oe;
    logic sdo_oe;
    logic [6:0] busy_len;
    logic busy_drop;
    int busy_lim;

    result_if conv_if ();
    result_if buf_if ();

    // Two-flop synchronisers on every pin input except sample_code_i
    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            pin_meta <= PIN_IDLE;
            pin_sync <= PIN_IDLE;
        end else begin
            pin_meta <= {convert_strobe_n_i, chip_select_n_i, read_n_i, ext_sclk_i,
                serial_data_in_i, fast_mode_i, low_power_i, serial_select_i,
                master_select_i, clock_divider_select_i};
            pin_sync <= pin_meta;
        end
    end

    assign {strobe_n_s, cs_n_s, rd_n_s, ext_sclk_s, sdi_s, fast_s, low_s, ser_s,
        mst_s, div_s} = pin_sync;

    // Edge detectors on synchronised strobe and slave clock
    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            strobe_prev <= 1'b1;
            sclk_prev <= 1'b0;
        end else begin
            strobe_prev <= strobe_n_s;
            sclk_prev <= ext_sclk_s;
        end
    end

    // Strobes while busy are ignored
    assign start = strobe_prev & !strobe_n_s & (state == CV_IDLE); // R01
    assign ext_fall = sclk_prev & !ext_sclk_s;

    // Speed mode decode
    always_comb begin
        if (fast_s && !low_s) begin
            next_mode = MODE_FAST; // R22
        end else if (low_s && !fast_s) begin
            next_mode = MODE_LOW; // R23
        end else begin
            next_mode = MODE_NORM; // R24
        end
    end

    // Result offered to the buffer once conversion ends
    assign conv_if.valid = (state == CV_PUSH);
    assign conv_if.data = code;

    // Conversion sequencer
    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            state <= CV_IDLE;
            cnt <= 4'h0;
            code <= '0;
            mode <= MODE_NORM;
            conv_ser <= 1'b0;
            conv_mst <= 1'b0;
        end else begin
            case (state)
                CV_IDLE: begin
                    if (start) begin
                        code <= sample_code_i;
                        mode <= next_mode;
                        conv_ser <= ser_s;
                        conv_mst <= mst_s;
                        cnt <= conv_cyc(next_mode) - 4'h1; // R05
                        state <= CV_CONV;
                    end
                end
                CV_CONV: begin
                    if (cnt == 4'h0) begin
                        state <= CV_PUSH;
                    end else begin
                        cnt <= cnt - 4'h1;
                    end
                end
                CV_PUSH: begin
                    if (conv_if.ready) begin
                        state <= (conv_ser && !conv_mst) ? CV_IDLE : CV_DRAIN;
                    end
                end
                CV_DRAIN: begin
                    if (busy_drop) begin
                        state <= CV_IDLE;
                    end
                end
                default: state <= CV_IDLE;
            endcase
        end
    end

    // Busy ends once the buffer takes the result in slave mode, once the shifter is done if master was selected, else once data_o loads
    always_comb begin
        if (state == CV_PUSH) begin
            busy_drop = conv_if.ready && conv_ser && !conv_mst;
        end else if (state == CV_DRAIN) begin
            busy_drop = conv_mst ? shift_done : par_landed; // R13 R08
        end else begin
            busy_drop = 1'b0;
        end
    end

    // Busy flag
    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            busy_o <= 1'b0;
        end else if (start) begin
            busy_o <= 1'b1; // R03
        end else if (busy_drop) begin
            busy_o <= 1'b0; // R04 R06 R18 R19 R20
        end
    end

    // Parallel output register and its drive enable
    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            data_o <= '0;
            par_landed <= 1'b0;
            data_oe_o <= 1'b0;
        end else begin
            par_landed <= buf_if.valid & buf_if.ready & !ser_s;
            if (buf_if.valid && buf_if.ready && !ser_s) begin
                data_o <= buf_if.data; // R07
            end
            data_oe_o <= !ser_s & !cs_n_s & !rd_n_s; // R09
        end
    end

    // Serial drive enables follow chip select; slave drives data only
    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            ser_oe <= 1'b0;
            sdo_oe <= 1'b0;
        end else begin
            ser_oe <= ser_s & mst_s & !cs_n_s; // R10 R11
            sdo_oe <= ser_s & !cs_n_s; // R11
        end
    end

    assign frame_oe_o = ser_oe;
    assign sclk_oe_o = ser_oe;
    assign serial_data_out_oe_o = sdo_oe;
    assign frame_o = shift_frame;
    assign sclk_o = shift_sclk;
    assign serial_data_out_o = shift_sdo;

    result_buffer buffer (
        .sys_clk_i(sys_clk_i),
        .reset_n_i(reset_n_i),
        .in_s(conv_if.snk),
        .out_s(buf_if.src)
    );

    serial_shifter shifter (
        .sys_clk_i(sys_clk_i),
        .reset_n_i(reset_n_i),
        .word_s(buf_if.snk),
        .serial_en_i(ser_s),
        .master_i(mst_s),
        .clock_divider_select_i(div_s),
        .ext_fall_i(ext_fall),
        .serial_data_in_i(sdi_s),
        .frame_o(shift_frame),
        .sclk_o(shift_sclk),
        .serial_data_out_o(shift_sdo),
        .done_o(shift_done)
    );

    // Busy width counter, helper for the checks below
    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            busy_len <= 7'h0;
        end else if (busy_o) begin
            busy_len <= busy_len + 7'h1;
        end else begin
            busy_len <= 7'h0;
        end
    end

    // Cycle limit for the latched mode
    always_comb begin
        case (mode)
            MODE_FAST: busy_lim = BUSY_FAST_CYC;
            MODE_LOW: busy_lim = BUSY_LOW_CYC;
            default: busy_lim = BUSY_NORM_CYC;
        endcase
    end

    busy_rise_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // R03
        start |=> busy_o)
        else $error("busy did not rise after strobe");

    busy_width_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // R04
        busy_o && !conv_ser |-> int'(busy_len) < busy_lim)
        else $error("busy stayed high too long");

    conv_time_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // R05
        $rose(state == CV_CONV) |-> ##[1:10] state == CV_PUSH)
        else $error("conversion did not finish in time");

    busy_after_end_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // R06
        $rose(state == CV_PUSH) |-> busy_o)
        else $error("busy fell with end of conversion");

    data_early_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // R07
        par_landed && busy_o |-> int'(busy_len) == busy_lim - 1)
        else $error("parallel result late");

    data_before_busy_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // R08
        $fell(busy_o) && !conv_ser |-> $past(par_landed) && $stable(data_o))
        else $error("busy fell before parallel data valid");

    read_drive_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // R09
        !ser_s && !cs_n_s && !rd_n_s |=> data_oe_o)
        else $error("parallel data not driven on read");

    serial_drive_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // R10
        ser_s && mst_s && !cs_n_s |=> frame_oe_o && sclk_oe_o && serial_data_out_oe_o)
        else $error("serial pins not driven on chip select");

    serial_release_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // R11
        cs_n_s |=> !frame_oe_o && !sclk_oe_o && !serial_data_out_oe_o)
        else $error("serial pins not released");

    frame_busy_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // R13
        $fell(frame_o) && busy_o |=> !busy_o)
        else $error("busy not lowered one cycle after frame");

    mode_pick_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // R22
        start && fast_s && !low_s |=> mode == MODE_FAST)
        else $error("fastest mode not selected");

    parallel_c: cover property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        $fell(busy_o) && !conv_ser);

    master_c: cover property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        $fell(frame_o) && conv_mst);

    slave_c: cover property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        shift_done && !mst_s);

    stall_c: cover property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        state == CV_PUSH && !conv_if.ready);

endmodule
`default_nettype wire

// *** rtl/sar_pkg.sv ***
package sar_pkg;

    // Clock
    localparam int CLK_PERIOD_NS = 100;

    // Conversion time limits per mode
    localparam int CONV_FAST_NS = 750;
    localparam int CONV_NORM_NS = 1000;
    localparam int CONV_LOW_NS = 1250;

    // Busy cycles spent outside the conversion count itself
    localparam int BUSY_OVERHEAD_CYC = 3;

    // Longest busy width per mode, rounded down to cycles
    localparam int BUSY_FAST_CYC = CONV_FAST_NS / CLK_PERIOD_NS;
    localparam int BUSY_NORM_CYC = CONV_NORM_NS / CLK_PERIOD_NS;
    localparam int BUSY_LOW_CYC = CONV_LOW_NS / CLK_PERIOD_NS;

    // Frame to first serial clock edge, least time
    localparam int LEAD_DIV0_NS = 4;
    localparam int LEAD_DIVN_NS = 20;

    // Serial clock period, least time per divider code
    localparam int PERIOD_DIV0_NS = 25;
    localparam int PERIOD_DIV1_NS = 50;
    localparam int PERIOD_DIV2_NS = 100;
    localparam int PERIOD_DIV3_NS = 200;

    // Last serial clock edge to frame change, least time
    localparam int TAIL_DIV0_NS = 3;
    localparam int TAIL_DIV1_NS = 60;
    localparam int TAIL_DIV2_NS = 140;
    localparam int TAIL_DIV3_NS = 300;

    // Word layout and pin synchroniser reset pattern
    localparam int DATA_W = 16;
    localparam logic [10:0] PIN_IDLE = 11'h700;

    typedef enum logic [2:0] {
        MODE_FAST = 3'b001,
        MODE_NORM = 3'b010,
        MODE_LOW = 3'b100
    } mode_type;

    // Least time in whole cycles, never below one
    function automatic logic [3:0] cyc_up(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 4'h1 : 4'(c);
    endfunction

    function automatic logic [3:0] conv_cyc(input mode_type m);
        case (m)
            MODE_FAST: return 4'(BUSY_FAST_CYC - BUSY_OVERHEAD_CYC);
            MODE_LOW: return 4'(BUSY_LOW_CYC - BUSY_OVERHEAD_CYC);
            default: return 4'(BUSY_NORM_CYC - BUSY_OVERHEAD_CYC);
        endcase
    endfunction

    function automatic logic [3:0] half_cyc(input logic [1:0] d);
        case (d)
            2'h0: return cyc_up(PERIOD_DIV0_NS / 2);
            2'h1: return cyc_up(PERIOD_DIV1_NS / 2);
            2'h2: return cyc_up(PERIOD_DIV2_NS / 2);
            default: return cyc_up(PERIOD_DIV3_NS / 2);
        endcase
    endfunction

    function automatic logic [3:0] lead_cyc(input logic [1:0] d);
        return (d == 2'h0) ? cyc_up(LEAD_DIV0_NS) : cyc_up(LEAD_DIVN_NS);
    endfunction

    function automatic logic [3:0] tail_cyc(input logic [1:0] d);
        case (d)
            2'h0: return cyc_up(TAIL_DIV0_NS);
            2'h1: return cyc_up(TAIL_DIV1_NS);
            2'h2: return cyc_up(TAIL_DIV2_NS);
            default: return cyc_up(TAIL_DIV3_NS);
        endcase
    endfunction

endpackage

// *** rtl/serial_shifter.sv ***
`timescale 1ns/10ps
`default_nettype none
module serial_shifter
    import sar_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    // Word source
    result_if.snk word_s,
    // Port selection
    input wire logic serial_en_i,
    input wire logic master_i,
    input wire logic [1:0] clock_divider_select_i,
    // Slave side clock edge and daisy-chain input
    input wire logic ext_fall_i,
    input wire logic serial_data_in_i,
    // Serial pins and end of word
    output logic frame_o,
    output logic sclk_o,
    output logic serial_data_out_o,
    output logic done_o
);

    typedef enum logic [4:0] {
        SH_IDLE = 5'b00001,
        SH_LEAD = 5'b00010,
        SH_CLK = 5'b00100,
        SH_TAIL = 5'b01000,
        SH_SLAVE = 5'b10000
    } shift_state_type;

    shift_state_type state;
    logic [DATA_W-1:0] shreg;
    logic [3:0] bits;
    logic [3:0] cnt;
    logic [1:0] div;

    // Parallel reading pops at once; serial waits for an idle shifter
    assign word_s.ready = !serial_en_i | (state == SH_IDLE);

    // Frame, clock and shift sequencing
    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            state <= SH_IDLE;
            shreg <= '0;
            bits <= 4'h0;
            cnt <= 4'h0;
            div <= 2'h0;
            frame_o <= 1'b0;
            sclk_o <= 1'b0;
            serial_data_out_o <= 1'b0;
            done_o <= 1'b0;
        end else begin
            done_o <= 1'b0;
            case (state)
                SH_IDLE: begin
                    if (serial_en_i && word_s.valid) begin
                        shreg <= word_s.data;
                        serial_data_out_o <= word_s.data[DATA_W-1];
                        bits <= 4'h0;
                        div <= clock_divider_select_i;
                        if (master_i) begin
                            frame_o <= 1'b1; // R12
                            cnt <= lead_cyc(clock_divider_select_i); // R16
                            state <= SH_LEAD;
                        end else begin
                            state <= SH_SLAVE;
                        end
                    end
                end
                SH_LEAD: begin
                    if (cnt == 4'h1) begin
                        cnt <= half_cyc(div); // R14 R15
                        state <= SH_CLK;
                    end else begin
                        cnt <= cnt - 4'h1;
                    end
                end
                SH_CLK: begin
                    if (cnt == 4'h1) begin
                        cnt <= half_cyc(div); // R14 R15
                        sclk_o <= ~sclk_o;
                        if (sclk_o) begin
                            serial_data_out_o <= shreg[DATA_W-2];
                            shreg <= {shreg[DATA_W-2:0], 1'b0};
                            bits <= bits + 4'h1;
                            if (bits == 4'hf) begin
                                cnt <= tail_cyc(div); // R17
                                state <= SH_TAIL;
                            end
                        end
                    end else begin
                        cnt <= cnt - 4'h1;
                    end
                end
                SH_TAIL: begin
                    if (cnt == 4'h1) begin
                        frame_o <= 1'b0; // R17
                        done_o <= 1'b1;
                        state <= SH_IDLE;
                    end else begin
                        cnt <= cnt - 4'h1;
                    end
                end
                SH_SLAVE: begin
                    if (ext_fall_i) begin
                        serial_data_out_o <= shreg[DATA_W-2]; // R21
                        shreg <= {shreg[DATA_W-2:0], serial_data_in_i};
                        bits <= bits + 4'h1;
                        if (bits == 4'hf) begin
                            done_o <= 1'b1;
                            state <= SH_IDLE;
                        end
                    end
                end
                default: state <= SH_IDLE;
            endcase
        end
    end

    // Clock stays idle-low from frame until first edge
    first_edge_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // R16
        $rose(frame_o) |-> !sclk_o [*2])
        else $error("serial clock moved too soon after frame");

    // Frame drops only after clock settled low
    last_edge_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // R17
        $fell(frame_o) |-> !sclk_o && $past(!sclk_o))
        else $error("frame dropped too close to last clock edge");

    // Each clock half lasts its divider count
    clock_half_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // R14
        $changed(sclk_o) && frame_o && half_cyc(div) == 4'h1 |=> $changed(sclk_o) || !frame_o
        || state == SH_TAIL)
        else $error("serial clock half period wrong");

endmodule
`default_nettype wire

// *** sim/host_reader.sv ***
`timescale 1ns/10ps
`default_nettype none
// Host that collects words from the master serial port
module host_reader (
    // Serial pins from the converter
    input wire logic frame_i,
    input wire logic frame_oe_i,
    input wire logic sclk_i,
    input wire logic sdo_i,
    input wire logic sdo_oe_i,
    // Collected word
    output logic [15:0] word_o
);
    logic last;
    logic sdo_w;
    // A released data line shows the inverse of its last level
    assign sdo_w = sdo_oe_i ? sdo_i : ~last;
    initial begin
        word_o = 16'h0000;
        last = 1'b0;
    end
    // MSB first, sampled on rising serial clock inside a frame
    always @(posedge sclk_i) begin
        if (frame_i && frame_oe_i) begin
            word_o <= {word_o[14:0], sdo_w};
        end
        last <= sdo_w;
    end
endmodule
`default_nettype wire

// *** sim/sar_adc_readout_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module sar_adc_readout_tb;
    logic sys_clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic convert_strobe_n_i = 1'b1;
    logic fast_mode_i = 1'b0;
    logic low_power_i = 1'b0;
    logic serial_select_i = 1'b0;
    logic master_select_i = 1'b0;
    logic chip_select_n_i = 1'b1;
    logic read_n_i = 1'b1;
    logic ext_sclk_i = 1'b0;
    logic serial_data_in_i = 1'b0;
    logic [1:0] clock_divider_select_i = 2'h0;
    logic [15:0] sample_code_i = 16'h0000;
    logic [15:0] data_o;
    logic [15:0] host_word;
    logic [15:0] got;
    logic data_oe_o, frame_o, frame_oe_o, sclk_o, sclk_oe_o;
    logic serial_data_out_o, serial_data_out_oe_o, busy_o;
    logic [15:0] wexp [4] = '{16'h000a, 16'h0007, 16'h000c, 16'h000a};
    // Master busy: conversion, lead, 32 clock halves of 100 ns, tail, drop
    int bmax [4] = '{41, 41, 42, 43};
    int n_errors = 0;
    int num_checks = 0;
    int w;
    int i;

    // Clock of 100 ns
    always #50 sys_clk_i = ~sys_clk_i;

    sar_adc_readout dut_u (
        .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
        .convert_strobe_n_i(convert_strobe_n_i), .fast_mode_i(fast_mode_i),
        .low_power_i(low_power_i), .sample_code_i(sample_code_i),
        .serial_select_i(serial_select_i), .master_select_i(master_select_i),
        .clock_divider_select_i(clock_divider_select_i),
        .chip_select_n_i(chip_select_n_i), .read_n_i(read_n_i),
        .data_o(data_o), .data_oe_o(data_oe_o),
        .ext_sclk_i(ext_sclk_i), .serial_data_in_i(serial_data_in_i),
        .frame_o(frame_o), .frame_oe_o(frame_oe_o),
        .sclk_o(sclk_o), .sclk_oe_o(sclk_oe_o),
        .serial_data_out_o(serial_data_out_o),
        .serial_data_out_oe_o(serial_data_out_oe_o), .busy_o(busy_o)
    );

    host_reader host_u (
        .frame_i(frame_o), .frame_oe_i(frame_oe_o), .sclk_i(sclk_o),
        .sdo_i(serial_data_out_o), .sdo_oe_i(serial_data_out_oe_o),
        .word_o(host_word)
    );

    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic close_out();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // One conversion; returns busy width in cycles, 300 if stalled
    task automatic conv(input logic [15:0] c, output int wd);
        int t;
        repeat (20) @(negedge sys_clk_i);
        sample_code_i = c;
        convert_strobe_n_i = 1'b0;
        repeat (2) @(negedge sys_clk_i);
        convert_strobe_n_i = 1'b1;
        t = 0;
        while (busy_o !== 1'b1 && t < 20) begin
            @(negedge sys_clk_i);
            t++;
        end
        wd = 0;
        while (busy_o === 1'b1 && wd < 300) begin
            @(negedge sys_clk_i);
            wd++;
        end
    endtask

    // Slave read, falling external clock edges, MSB first
    task automatic rd_slave(output logic [15:0] wd);
        repeat (4) @(negedge sys_clk_i);
        for (int k = 15; k >= 0; k--) begin
            wd[k] = serial_data_out_oe_o ? serial_data_out_o : ~serial_data_out_o;
            ext_sclk_i = 1'b1;
            repeat (2) @(negedge sys_clk_i);
            ext_sclk_i = 1'b0;
            repeat (4) @(negedge sys_clk_i);
        end
    endtask

    // Watchdog
    initial begin
        #(20000 * 100);
        n_errors++;
        close_out();
    end

    // Main sequence
    initial begin
        repeat (20) @(negedge sys_clk_i);
        reset_n_i = 1'b1;
        chk("busy_reset", busy_o, 16'h0000);
        chk("data_oe_reset", data_oe_o, 16'h0000);
        // Parallel port over all mode input pairs
        for (i = 0; i < 4; i++) begin
            fast_mode_i = i[0];
            low_power_i = i[1];
            conv(16'ha5c0 + 16'(i), w);
            chk("busy_width", 16'(w), wexp[i]);
            chk("data", data_o, 16'ha5c0 + 16'(i));
        end
        chip_select_n_i = 1'b0;
        read_n_i = 1'b0;
        repeat (4) @(negedge sys_clk_i);
        chk("data_oe", data_oe_o, 16'h0001);
        serial_select_i = 1'b1;
        repeat (4) @(negedge sys_clk_i);
        chk("data_oe_serial", data_oe_o, 16'h0000);
        // Master serial in fastest mode, every divider code
        master_select_i = 1'b1;
        fast_mode_i = 1'b1;
        low_power_i = 1'b0;
        for (i = 0; i < 4; i++) begin
            clock_divider_select_i = 2'(i);
            conv(16'h3c90 + 16'(i), w);
            chk("frame_oe", frame_oe_o, 16'h0001);
            chk("sclk_oe", sclk_oe_o, 16'h0001);
            chk("host_word", host_word, 16'h3c90 + 16'(i));
            chk("busy_master", 16'(w), 16'(bmax[i]));
            chk("frame_end", frame_o, 16'h0000);
        end
        chip_select_n_i = 1'b1;
        repeat (4) @(negedge sys_clk_i);
        chk("frame_oe_off", frame_oe_o, 16'h0000);
        chk("sclk_oe_off", sclk_oe_o, 16'h0000);
        chk("sdo_oe_off", serial_data_out_oe_o, 16'h0000);
        // Slave serial: fill shifter and buffer until it stalls
        master_select_i = 1'b0;
        chip_select_n_i = 1'b0;
        for (i = 0; i < 3; i++) begin
            conv(16'h1234 + 16'(i), w);
            chk("busy_slave", 16'(w), 16'h0005);
        end
        conv(16'h1237, w);
        chk("busy_stall", 16'(w), 16'h012c);
        for (i = 0; i < 4; i++) begin
            rd_slave(got);
            chk("slave_word", got, 16'h1234 + 16'(i));
        end
        close_out();
    end
endmodule
`default_nettype wire
